//--- oefm_flags.sv
`timescale 1ns/1ps
`default_nettype none
`include "oefm_map.svh"

module oefm_flags
    import oefm_pkg::*;
#(
    parameter int unsigned SUSPEND_CYCLES =
        (`OEFM_CLK_HZ / 1000000) * `OEFM_SUSPEND_US + 1,
    parameter int unsigned LONG_SE0_CYCLES =
        (`OEFM_CLK_HZ / 1000000) * `OEFM_LONG_SE0_US + 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Port conditions and bus line states
    input wire oefm_cond_t cond_i,
    input wire oefm_line_t line_i,
    // Interrupt and status
    output logic irq_o,
    output logic suspended_o
);

    if (SUSPEND_CYCLES < 2 || LONG_SE0_CYCLES < 2) begin : g_bad_counts
        $error("oefm_flags: counts must be at least 2");
    end

    ////////////////////////////////////////////////////////////////////////
    oefm_state_t cur_ff;
    oefm_state_t nxt_cur;
    logic [15:0] ev;
    logic [15:0] w1c;
    logic access;
    logic mapped;
    logic [31:0] idle_lim;
    logic [31:0] se0_lim;

    assign idle_lim = 32'(SUSPEND_CYCLES);
    assign se0_lim = 32'(LONG_SE0_CYCLES);
    assign access = psel_i && penable_i && !cur_ff.pready;

    always_comb begin
        nxt_cur = cur_ff;
        ev = 16'h0000;
        w1c = 16'h0000;
        mapped = 1'b0;
        nxt_cur.cond = cond_i;
        // Edge detectors against last sampled condition
        ev[`OEFM_BIT_PLUG_ID] = cond_i.plug_id_level != cur_ff.cond.plug_id_level;
        ev[`OEFM_BIT_SUPPLY] =
            cond_i.host_supply_valid != cur_ff.cond.host_supply_valid;
        ev[`OEFM_BIT_SESS_END] =
            cond_i.periph_session_end != cur_ff.cond.periph_session_end;
        ev[`OEFM_BIT_HOST_SESS] =
            cond_i.host_session_valid != cur_ff.cond.host_session_valid;
        ev[`OEFM_BIT_PER_SESS] =
            cond_i.periph_session_valid != cur_ff.cond.periph_session_valid;
        ev[`OEFM_BIT_REMOTE] =
            cond_i.remote_connected != cur_ff.cond.remote_connected;
        ev[`OEFM_BIT_SRP] = line_i.session_request_seen;
        ev[`OEFM_BIT_TIMEOUT] = line_i.timeout_event;

        // Idle timer; suspend entered once idle exceeds 3 ms
        nxt_cur.last_j = line_i.bus_j;
        if (!line_i.bus_idle) begin
            nxt_cur.idle_cnt = 32'h00000000;
        end else if (cur_ff.idle_cnt < idle_lim) begin
            nxt_cur.idle_cnt = cur_ff.idle_cnt + 32'h00000001;
        end
        case (cur_ff.port_state)
            OEFM_ACTIVE: begin
                if (line_i.bus_idle && cur_ff.idle_cnt == idle_lim - 32'h00000001) begin
                    nxt_cur.port_state = OEFM_SUSPENDED;
                    ev[`OEFM_BIT_SUSPEND] = 1'b1;
                end
            end
            OEFM_SUSPENDED: begin
                // Only a J-to-K step counts as wakeup
                if (cur_ff.last_j && line_i.bus_k) begin
                    ev[`OEFM_BIT_WAKEUP] = 1'b1;
                    nxt_cur.port_state = OEFM_ACTIVE;
                end else if (!line_i.bus_idle) begin
                    nxt_cur.port_state = OEFM_ACTIVE;
                end
            end
            default: nxt_cur.port_state = OEFM_ACTIVE;
        endcase
        nxt_cur.suspended = nxt_cur.port_state == OEFM_SUSPENDED;

        // Long SE0 fires once per SE0 period
        if (!line_i.bus_se0) begin
            nxt_cur.se0_cnt = 32'h00000000;
            nxt_cur.se0_done = 1'b0;
        end else if (!cur_ff.se0_done) begin
            nxt_cur.se0_cnt = cur_ff.se0_cnt + 32'h00000001;
            if (cur_ff.se0_cnt == se0_lim - 32'h00000001) begin
                ev[`OEFM_BIT_LONG_SE0] = 1'b1;
                nxt_cur.se0_done = 1'b1;
            end
        end

        // APB: one wait state, answer in second access cycle
        nxt_cur.pready = access;
        nxt_cur.pslverr = 1'b0;
        if (access) begin
            nxt_cur.prdata = 32'h00000000;
            if (pwrite_i) begin
                case (paddr_i)
                    `OEFM_ADDR_FLAGS: begin
                        mapped = 1'b1;
                        w1c = pwdata_i[15:0] & `OEFM_IMPL_BITS;
                    end
                    `OEFM_ADDR_MASK_W: begin
                        mapped = 1'b1;
                        nxt_cur.mask = pwdata_i[15:0] & `OEFM_IMPL_BITS;
                    end
                    default: mapped = 1'b0;
                endcase
            end else begin
                case (paddr_i)
                    `OEFM_ADDR_FLAGS: begin
                        mapped = 1'b1;
                        nxt_cur.prdata = {16'h0000, cur_ff.flags};
                    end
                    `OEFM_ADDR_MASK: begin
                        mapped = 1'b1;
                        nxt_cur.prdata = {16'h0000, cur_ff.mask};
                    end
                    `OEFM_ADDR_COND: begin
                        mapped = 1'b1;
                        nxt_cur.prdata = {25'h0000000, cur_ff.port_state == OEFM_SUSPENDED,
                            cur_ff.cond};
                    end
                    default: mapped = 1'b0;
                endcase
            end
            nxt_cur.pslverr = !mapped;
        end

        // Set wins over clear; masking never blocks latching
        nxt_cur.flags = ((cur_ff.flags & ~w1c) | ev) & `OEFM_IMPL_BITS;
        // Per-bit gating covers all eleven flags, bits 0 through 10
        nxt_cur.irq = |(nxt_cur.flags & nxt_cur.mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_ff.flags <= `OEFM_RST_FLAGS;
            cur_ff.mask <= `OEFM_RST_MASK;
            cur_ff.cond <= '0;
            cur_ff.last_j <= 1'b0;
            cur_ff.idle_cnt <= 32'h00000000;
            cur_ff.se0_cnt <= 32'h00000000;
            cur_ff.se0_done <= 1'b0;
            cur_ff.port_state <= OEFM_ACTIVE;
            cur_ff.suspended <= 1'b0;
            cur_ff.pready <= 1'b0;
            cur_ff.pslverr <= 1'b0;
            cur_ff.prdata <= 32'h00000000;
            cur_ff.irq <= 1'b0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign prdata_o = cur_ff.prdata;
    assign pready_o = cur_ff.pready;
    assign pslverr_o = cur_ff.pslverr;
    assign irq_o = cur_ff.irq;
    assign suspended_o = cur_ff.suspended;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    logic past_valid_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            past_valid_ff <= 1'b0;
        end else begin
            past_valid_ff <= 1'b1;
        end
    end

    // Reference run lengths, kept apart from the datapath counters
    logic [31:0] idle_run_ff;
    logic [31:0] se0_run_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            idle_run_ff <= 32'h00000000;
            se0_run_ff <= 32'h00000000;
        end else begin
            if (!line_i.bus_idle) begin
                idle_run_ff <= 32'h00000000;
            end else if (idle_run_ff != 32'hFFFFFFFF) begin
                idle_run_ff <= idle_run_ff + 32'h00000001;
            end
            if (!line_i.bus_se0) begin
                se0_run_ff <= 32'h00000000;
            end else if (se0_run_ff != 32'hFFFFFFFF) begin
                se0_run_ff <= se0_run_ff + 32'h00000001;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || !past_valid_ff);

    // Change and event detectors: flag visible one edge after the change or event
    a_remote_chg_sets: assert property (
        cond_i.remote_connected != cur_ff.cond.remote_connected |=> cur_ff.flags[5])
        else $error("remote change flag not set");
    a_plug_chg_sets: assert property (
        cond_i.plug_id_level != cur_ff.cond.plug_id_level |=> cur_ff.flags[0])
        else $error("plug id flag not set");
    a_psess_chg_sets: assert property (
        $changed(cond_i.periph_session_valid) |=> cur_ff.flags[4])
        else $error("peripheral session flag not set");
    a_hsess_chg_sets: assert property (
        $changed(cond_i.host_session_valid) |=> cur_ff.flags[3])
        else $error("host session flag not set");
    a_send_chg_sets: assert property (
        $changed(cond_i.periph_session_end) |=> cur_ff.flags[2])
        else $error("session end flag not set");
    a_supply_chg_sets: assert property (
        $changed(cond_i.host_supply_valid) |=> cur_ff.flags[1])
        else $error("supply flag not set");
    a_remote_quiet: assert property (
        !cur_ff.flags[5] && $stable(cond_i.remote_connected) |=> !cur_ff.flags[5])
        else $error("remote flag without change");
    a_plug_quiet: assert property (
        !cur_ff.flags[0] && $stable(cond_i.plug_id_level) |=> !cur_ff.flags[0])
        else $error("plug id flag without change");
    a_psess_quiet: assert property (
        !cur_ff.flags[4] && $stable(cond_i.periph_session_valid) |=> !cur_ff.flags[4])
        else $error("peripheral session flag without change");
    a_hsess_quiet: assert property (
        !cur_ff.flags[3] && $stable(cond_i.host_session_valid) |=> !cur_ff.flags[3])
        else $error("host session flag without change");
    a_send_quiet: assert property (
        !cur_ff.flags[2] && $stable(cond_i.periph_session_end) |=> !cur_ff.flags[2])
        else $error("session end flag without change");
    a_supply_quiet: assert property (
        !cur_ff.flags[1] && $stable(cond_i.host_supply_valid) |=> !cur_ff.flags[1])
        else $error("supply flag without change");
    a_timeout_sets: assert property (
        line_i.timeout_event |=> cur_ff.flags[10])
        else $error("timeout flag not set");
    a_timeout_quiet: assert property (
        !cur_ff.flags[10] && !line_i.timeout_event |=> !cur_ff.flags[10])
        else $error("timeout flag without event");
    a_srp_sets: assert property (
        line_i.session_request_seen |=> cur_ff.flags[8])
        else $error("session request flag not set");
    a_srp_quiet: assert property (
        !cur_ff.flags[8] && !line_i.session_request_seen |=> !cur_ff.flags[8])
        else $error("session request flag without event");
    a_wakeup_sets: assert property (
        suspended_o && cur_ff.last_j && line_i.bus_k |=> cur_ff.flags[7])
        else $error("wakeup flag not set");
    a_wake_only_jk: assert property (
        !cur_ff.flags[7] && !(suspended_o && cur_ff.last_j && line_i.bus_k)
        |=> !cur_ff.flags[7])
        else $error("wakeup flag without J-to-K");

    // Timed events against the reference run lengths
    a_suspend_flag: assert property (
        cur_ff.port_state == OEFM_ACTIVE ##1 cur_ff.port_state == OEFM_SUSPENDED
        |-> cur_ff.flags[6])
        else $error("suspend flag missing");
    a_idle_suspend: assert property (
        !suspended_o && line_i.bus_idle && idle_run_ff == idle_lim - 32'h00000001
        |=> suspended_o && cur_ff.flags[6])
        else $error("suspend not entered after idle limit");
    a_no_early_suspend: assert property (
        !suspended_o && idle_run_ff < idle_lim - 32'h00000001 |=> !suspended_o)
        else $error("suspend entered too early");
    a_se0_sets: assert property (
        line_i.bus_se0 && se0_run_ff == se0_lim - 32'h00000001 |=> cur_ff.flags[9])
        else $error("long SE0 flag not set");
    a_se0_not_early: assert property (
        !cur_ff.flags[9] && se0_run_ff < se0_lim - 32'h00000001 |=> !cur_ff.flags[9])
        else $error("long SE0 flag too early");

    // Sticky flags and software clear
    a_flag_sticky: assert property (
        cur_ff.flags[0] && !(access && pwrite_i && paddr_i == `OEFM_ADDR_FLAGS
        && pwdata_i[0]) |=> cur_ff.flags[0])
        else $error("flag dropped without write one");
    a_w1c_clears: assert property (
        access && pwrite_i && paddr_i == `OEFM_ADDR_FLAGS && pwdata_i[0]
        && cond_i.plug_id_level == cur_ff.cond.plug_id_level |=> !cur_ff.flags[0])
        else $error("write one did not clear flag");
    a_reserved_zero: assert property (
        cur_ff.flags[15:11] == 5'h00 && cur_ff.mask[15:11] == 5'h00)
        else $error("reserved bit set");
    a_latch_masked: assert property (
        line_i.timeout_event && !cur_ff.mask[10] |=> cur_ff.flags[10])
        else $error("masked event not latched");

    // Interrupt gating
    a_irq_level: assert property (
        irq_o == |(cur_ff.flags & cur_ff.mask))
        else $error("interrupt level wrong");
    a_masked_quiet: assert property (
        cur_ff.mask == 16'h0000 && $past(cur_ff.mask) == 16'h0000 |-> !irq_o)
        else $error("interrupt with all masked");
    a_timeout_gate: assert property (
        cur_ff.flags[10] && cur_ff.mask[10] |-> irq_o)
        else $error("timeout interrupt missing");
    a_se0_gate: assert property (
        cur_ff.flags[9] && cur_ff.mask[9] |-> irq_o)
        else $error("long SE0 interrupt missing");
    a_srp_gate: assert property (
        cur_ff.flags[8] && cur_ff.mask[8] |-> irq_o)
        else $error("session request interrupt missing");
    a_wakeup_gate: assert property (
        cur_ff.flags[7] && cur_ff.mask[7] |-> irq_o)
        else $error("wakeup interrupt missing");

    // Register access
    a_mask_write: assert property (
        access && pwrite_i && paddr_i == `OEFM_ADDR_MASK_W
        |=> cur_ff.mask == ($past(pwdata_i[15:0]) & `OEFM_IMPL_BITS))
        else $error("mask write lost");
    a_mask_held: assert property (
        !(access && pwrite_i && paddr_i == `OEFM_ADDR_MASK_W) |=> $stable(cur_ff.mask))
        else $error("mask changed without write");
    a_ready_answer: assert property (
        access |=> pready_o)
        else $error("bus answer missing");
    a_ready_pulse: assert property (
        pready_o |=> !pready_o)
        else $error("ready held too long");
    a_upper_zero: assert property (
        pready_o |-> prdata_o[31:16] == 16'h0000)
        else $error("upper read data not zero");
    a_err_with_ready: assert property (
        pslverr_o |-> pready_o)
        else $error("error without ready");
    a_suspended_out: assert property (
        suspended_o == (cur_ff.port_state == OEFM_SUSPENDED))
        else $error("suspend output out of step");

    c_suspend_wake: cover property (
        cur_ff.port_state == OEFM_SUSPENDED ##1 cur_ff.flags[7]);
    c_long_se0: cover property (ev[9]);
    c_irq_rise: cover property ($rose(irq_o));
    c_w1c_clear: cover property ($fell(cur_ff.flags[0]));
    c_masked_latch: cover property (line_i.timeout_event && !cur_ff.mask[10]);

endmodule

`default_nettype wire

//--- oefm_map.svh
`ifndef OEFM_MAP_SVH
`define OEFM_MAP_SVH

// Register byte addresses (flags and condition word aligned; mask codes 0x069 and 0x0E9 are not)
`define OEFM_ADDR_FLAGS 12'h068
`define OEFM_ADDR_MASK 12'h069
`define OEFM_ADDR_MASK_W 12'h0E9
`define OEFM_ADDR_COND 12'h070

// Flag bit positions
`define OEFM_BIT_PLUG_ID 0
`define OEFM_BIT_SUPPLY 1
`define OEFM_BIT_SESS_END 2
`define OEFM_BIT_HOST_SESS 3
`define OEFM_BIT_PER_SESS 4
`define OEFM_BIT_REMOTE 5
`define OEFM_BIT_SUSPEND 6
`define OEFM_BIT_WAKEUP 7
`define OEFM_BIT_SRP 8
`define OEFM_BIT_LONG_SE0 9
`define OEFM_BIT_TIMEOUT 10

// Reset values and implemented bits
`define OEFM_RST_MASK 16'h0000
`define OEFM_RST_FLAGS 16'h0000
`define OEFM_IMPL_BITS 16'h07FF

// Timing
`define OEFM_CLK_HZ 20000000
`define OEFM_SUSPEND_US 3000
`define OEFM_LONG_SE0_US 2000

`endif

//--- oefm_pkg.sv
package oefm_pkg;

    typedef struct packed {
        logic plug_id_level;
        logic host_supply_valid;
        logic periph_session_end;
        logic host_session_valid;
        logic periph_session_valid;
        logic remote_connected;
    } oefm_cond_t;

    typedef struct packed {
        logic bus_idle;
        logic bus_j;
        logic bus_k;
        logic bus_se0;
        logic session_request_seen;
        logic timeout_event;
    } oefm_line_t;

    typedef enum logic [1:0] {
        OEFM_ACTIVE,
        OEFM_SUSPENDED
    } oefm_port_state_t;

    typedef struct packed {
        logic [15:0] flags;
        logic [15:0] mask;
        oefm_cond_t cond;
        logic last_j;
        logic [31:0] idle_cnt;
        logic [31:0] se0_cnt;
        logic se0_done;
        oefm_port_state_t port_state;
        logic suspended;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
    } oefm_state_t;

endpackage

//--- oefm_bus_model.sv
`timescale 1ns/1ps
`default_nettype none

// Far side: port comparators and bus line states, changed only after a clock edge
module oefm_bus_model
    import oefm_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Toward the block
    output var oefm_cond_t cond_o,
    output var oefm_line_t line_o
);
    initial begin
        cond_o = '0;
        line_o = '0;
    end

    task automatic flip_cond(input int k);
        @(posedge clk_i);
        cond_o[k] <= ~cond_o[k];
    endtask

    // Event inputs are one-cycle pulses
    task automatic pulse(input logic srp, input logic tmo);
        @(posedge clk_i);
        line_o.session_request_seen <= srp;
        line_o.timeout_event <= tmo;
        @(posedge clk_i);
        line_o.session_request_seen <= 1'b0;
        line_o.timeout_event <= 1'b0;
    endtask

    task automatic set_line(input logic idle, input logic j, input logic k, input logic se0);
        @(posedge clk_i);
        line_o.bus_idle <= idle;
        line_o.bus_j <= j;
        line_o.bus_k <= k;
        line_o.bus_se0 <= se0;
    endtask
endmodule
`default_nettype wire

//--- otg_event_flags_and_masks_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "oefm_map.svh"

module otg_event_flags_and_masks_tb;
    import oefm_pkg::*;
    // Shortened counts keep the run brief
    localparam int SUS = 8;
    localparam int LSE0 = 6;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, irq_o, suspended_o;
    oefm_cond_t cond;
    oefm_line_t line;
    logic [31:0] rd;
    logic er;
    int err_count = 0;
    int n_checks = 0;

    always #25 clk_i = ~clk_i;

    oefm_flags #(.SUSPEND_CYCLES(SUS), .LONG_SE0_CYCLES(LSE0)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .cond_i(cond), .line_i(line),
        .irq_o(irq_o), .suspended_o(suspended_o));

    oefm_bus_model BUS (.clk_i(clk_i), .cond_o(cond), .line_o(line));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t bit %b expected %b", $time, got, exp);
        end
    endtask

    // Request held until pready is seen at a rising edge
    task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (n >= 20) begin
            err_count++;
            $display("CHECK FAILED t=%0t no bus answer", $time);
            final_report();
        end
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb_xfer(1'b0, a, 32'h0000_0000);
        chk_val(rd, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Latched flag, gated interrupt, write-zero keeps, write-one clears
    task automatic event_cycle(input int b);
        logic [31:0] m;
        m = 32'h1 << b;
        rd_chk(`OEFM_ADDR_FLAGS, m);
        chk_bit(irq_o, 1'b0);
        apb_xfer(1'b1, `OEFM_ADDR_MASK_W, m);
        idle(2);
        chk_bit(irq_o, 1'b1);
        apb_xfer(1'b1, `OEFM_ADDR_FLAGS, ~m & 32'h0000_07FF);
        rd_chk(`OEFM_ADDR_FLAGS, m);
        apb_xfer(1'b1, `OEFM_ADDR_FLAGS, m);
        idle(2);
        rd_chk(`OEFM_ADDR_FLAGS, 32'h0000_0000);
        chk_bit(irq_o, 1'b0);
        apb_xfer(1'b1, `OEFM_ADDR_MASK_W, 32'h0000_0000);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        idle(2);
        rst_i <= 1'b0;
        rd_chk(`OEFM_ADDR_FLAGS, 32'h0000_0000);
        rd_chk(`OEFM_ADDR_MASK, 32'h0000_0000);
        apb_xfer(1'b1, `OEFM_ADDR_MASK_W, 32'hFFFF_FFFF);
        rd_chk(`OEFM_ADDR_MASK, 32'h0000_07FF);
        apb_xfer(1'b1, `OEFM_ADDR_MASK_W, 32'h0000_0000);
        apb_xfer(1'b0, 12'h0FC, 32'h0000_0000);
        chk_bit(er, 1'b1);
        chk_val(rd, 32'h0000_0000);
        // Mask answers only its write code
        apb_xfer(1'b1, `OEFM_ADDR_MASK, 32'h0000_07FF);
        chk_bit(er, 1'b1);
        rd_chk(`OEFM_ADDR_MASK, 32'h0000_0000);
        // Each condition rises and falls; struct bit k maps to flag 5-k
        for (int i = 0; i < 6; i++) begin
            for (int d = 0; d < 2; d++) begin
                BUS.flip_cond(i);
                idle(2);
                event_cycle(5 - i);
            end
        end
        BUS.pulse(1'b1, 1'b0);
        idle(2);
        event_cycle(8);
        BUS.pulse(1'b0, 1'b1);
        idle(2);
        event_cycle(10);
        BUS.set_line(1'b0, 1'b0, 1'b0, 1'b1);
        idle(LSE0 + 4);
        BUS.set_line(1'b0, 1'b0, 1'b0, 1'b0);
        idle(2);
        event_cycle(9);
        apb_xfer(1'b1, `OEFM_ADDR_MASK_W, 32'h0000_0080);
        BUS.set_line(1'b1, 1'b0, 1'b0, 1'b0);
        idle(SUS + 4);
        chk_bit(suspended_o, 1'b1);
        rd_chk(`OEFM_ADDR_FLAGS, 32'h0000_0040);
        chk_bit(irq_o, 1'b0);
        rd_chk(`OEFM_ADDR_COND, 32'h0000_0040);
        // K straight from idle is no resume
        BUS.set_line(1'b1, 1'b0, 1'b1, 1'b0);
        idle(2);
        rd_chk(`OEFM_ADDR_FLAGS, 32'h0000_0040);
        chk_bit(suspended_o, 1'b1);
        BUS.set_line(1'b1, 1'b1, 1'b0, 1'b0);
        idle(2);
        BUS.set_line(1'b1, 1'b0, 1'b1, 1'b0);
        idle(2);
        rd_chk(`OEFM_ADDR_FLAGS, 32'h0000_00C0);
        chk_bit(irq_o, 1'b1);
        BUS.set_line(1'b0, 1'b0, 1'b0, 1'b0);
        apb_xfer(1'b1, `OEFM_ADDR_FLAGS, 32'h0000_00C0);
        idle(2);
        rd_chk(`OEFM_ADDR_FLAGS, 32'h0000_0000);
        chk_bit(suspended_o, 1'b0);
        final_report();
    end
endmodule
`default_nettype wire
